/* File: bench/fsp_host.sv */
`default_nettype none
module fsp_host (
  input  wire logic  pclk,
  output logic       link_sclk,
  output logic       link_req,
  output logic [2:0] link_op,
  output logic [fsp_pkg::SECTOR_BITS-1:0] link_sector,
  output logic [7:0] link_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    link_sclk = 1'b0;
    link_req = 1'b0;
    link_op = 3'h0;
    link_sector = 8'h00;
    link_data = 8'h00;
  end
  // one request per frame; clock stands low between frames
  // each half period is four pclk cycles, 160 ns in all
  task automatic send(input logic [2:0] op, input logic [7:0] s, d);
    @(posedge pclk);
    link_op <= op;
    link_sector <= s;
    link_data <= d;
    link_req <= 1'b1;
    repeat (4) @(posedge pclk);
    link_sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    link_sclk <= 1'b0;
    // flip released lines so stale values never look valid
    link_req <= 1'b0;
    link_op <= ~op;
    link_sector <= ~s;
    link_data <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: bench/fsp_props.sv */
`default_nettype none
module fsp_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        link_sclk,
  input wire logic        link_req,
  input wire logic [2:0]  link_op,
  input wire logic [fsp_pkg::SECTOR_BITS-1:0] link_sector,
  input wire logic [7:0]  link_data,
  input wire logic        write_protect_n,
  input wire logic [7:0]  link_rdata,
  input wire logic        link_reject,
  input wire logic        link_ack
);
  import fsp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  // pin must settle through the synchroniser first
  sequence wp_held;
    !write_protect_n [*8] ##1 acc && !pwrite && paddr == OFF_STATUS;
  endsequence
  sequence link_take;
    $rose(link_sclk) && link_req;
  endsequence
  a_ready_access: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_ready_idle: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without select");
  a_err_unmapped: assert property (acc && paddr > OFF_LAST |->
    pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mask_irq: assert property (acc && pwrite &&
    paddr == OFF_INT_MASK && pwdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
  a_ack_space: assert property ($changed(link_ack) |=>
    $stable(link_ack) [*4]) else $error("ack toggled twice");
  a_result_hold: assert property ($stable(link_ack) |->
    $stable(link_reject) && $stable(link_rdata))
    else $error("link result moved without ack");
  a_ack_after: assert property (link_take |->
    ##[2:8] $changed(link_ack)) else $error("request not answered");
  a_wp_status: assert property (wp_held |-> prdata[POS_WP])
    else $error("protect pin not shown in status");
endmodule
bind fsp_top fsp_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .link_sclk(link_sclk),
  .link_req(link_req), .link_op(link_op), .link_sector(link_sector),
  .link_data(link_data), .write_protect_n(write_protect_n),
  .link_rdata(link_rdata), .link_reject(link_reject),
  .link_ack(link_ack));
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, wp_n, sclk, req, reject, ack, se, reject_bb;
  logic [7:0]  paddr, ldata, rdata, sect, sa;
  logic [2:0]  op;
  logic [31:0] pwdata, prdata, rv;
  int          errors, cmp_count, cyc, n, k;
  fsp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_sclk(sclk), .link_req(req), .link_op(op), .link_sector(sect),
    .link_data(ldata), .write_protect_n(wp_n), .link_rdata(rdata),
    .link_reject(reject), .link_ack(ack));
  // second array shape: subsectors live in the low boot sectors
  fsp_top #(.ARCH(fsp_bottom_boot)) u_dut_bb (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .irq(), .link_sclk(sclk), .link_req(req), .link_op(op),
    .link_sector(sect), .link_data(ldata), .write_protect_n(wp_n),
    .link_rdata(), .link_reject(reject_bb), .link_ack());
  fsp_host u_host (.pclk(pclk), .link_sclk(sclk), .link_req(req),
    .link_op(op), .link_sector(sect), .link_data(ldata));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] ex, got);
    cmp_count++;
    if (got !== ex) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lk(input logic [2:0] o, input logic [7:0] s, d);
    logic a;
    a = ack;
    u_host.send(o, s, d);
    n = 0;
    while (ack === a && n < 30) begin
      @(posedge pclk);
      n++;
    end
    chk("ack", 1, ack !== a);
  endtask
  function automatic int sz(input int c);
    return c == 0 ? 0 : (c >= CODE_ALL_MIN ? 256 : 1 << (c - 1));
  endfunction
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wp_n = 1'b1;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STATUS, 0);
    chk("status", 0, rv);
    apb(0, OFF_INT_MASK, 0);
    chk("mask", 0, rv);
    lk(1, 5, 0);
    chk("lock", 0, rdata);
    $display("reset test done");
    lk(2, 5, 8'h01);
    lk(1, 5, 0);
    chk("lock", 1, rdata);
    lk(3, 5, 0);
    chk("reject", 1, reject);
    lk(4, 6, 0);
    chk("reject", 0, reject);
    apb(0, OFF_STATUS, 0);
    chk("flag", 1, rv[POS_PFLAG]);
    lk(2, 5, 8'h03);
    chk("reject", 0, reject);
    lk(2, 5, 8'h00);
    chk("reject", 1, reject);
    lk(1, 5, 0);
    chk("lock", 3, rdata);
    lk(5, 100, 0);
    chk("reject", 1, reject);
    apb(0, OFF_LAST, 0);
    chk("last", 32'h164, rv);
    lk(5, 3, 0);
    chk("reject", 1, reject);
    chk("boot", 0, reject_bb);
    lk(5, 250, 0);
    chk("boot", 1, reject_bb);
    $display("lock test done");
    // just inside and just outside each range edge, program and erase alternately
    for (int t = 0; t < 2; t++)
      for (int c = 0; c < 16; c++) begin
        lk(6, 0, 8'(c | t << 5));
        k = sz(c);
        for (int j = 0; j < 2; j++) begin
          sa = 8'(t ? k - 1 + j : 255 - k + j);
          lk(3'(3 + c % 2), sa, 0);
          chk("range", t ? sa < k : sa >= 256 - k, reject);
        end
      end
    $display("range test done");
    lk(6, 0, 8'h80);
    lk(0, 0, 0);
    chk("status", 8'h80, rdata);
    lk(7, 0, 0);
    apb(0, OFF_STATUS, 0);
    chk("flag", 0, rv[POS_PFLAG]);
    wp_n <= 1'b0;
    repeat (10) @(posedge pclk);
    lk(6, 0, 8'h05);
    chk("reject", 1, reject);
    apb(0, OFF_STATUS, 0);
    chk("status", 32'h380, rv);
    wp_n <= 1'b1;
    repeat (10) @(posedge pclk);
    lk(6, 0, 8'h02);
    chk("reject", 0, reject);
    $display("pin test done");
    apb(0, OFF_INT_STAT, 0);
    chk("istat", 32'hF, rv);
    apb(1, OFF_INT_MASK, 1);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    apb(1, OFF_INT_MASK, 0);
    repeat (2) @(posedge pclk);
    chk("irq", 0, irq);
    apb(1, OFF_INT_STAT, 32'hF);
    apb(0, OFF_INT_STAT, 0);
    chk("istat", 0, rv);
    apb(1, OFF_INT_MASK, 32'hF);
    apb(0, OFF_INT_MASK, 0);
    chk("mask", 32'hF, rv);
    chk("irq", 0, irq);
    lk(3, 200, 0);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    apb(1, OFF_STATUS, 32'hFF);
    apb(0, OFF_STATUS, 0);
    chk("status", 32'h202, rv);
    apb(0, 8'h10, 0);
    chk("slverr", 1, se);
    chk("unmapped", 0, rv);
    $display("register test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    lk(1, 5, 0);
    chk("lock", 0, rdata);
    lk(2, 5, 8'h01);
    chk("reject", 0, reject);
    $display("power-up test done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/fsp_pkg.sv */
`default_nettype none
package fsp_pkg;
  localparam int unsigned NUM_SECTORS   = 256;
  localparam int unsigned SECTOR_BITS   = 8;
  localparam int unsigned BOOT_SECTORS  = 8;
  localparam int unsigned BOOT_SUBSECTS = 16;
  localparam int unsigned CODE_ALL_MIN  = 9;
  localparam int unsigned SECTOR_KBYTES = 64;

  // apb byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;
  localparam logic [7:0] OFF_INT_STAT = 8'h04;
  localparam logic [7:0] OFF_INT_MASK = 8'h08;
  localparam logic [7:0] OFF_LAST     = 8'h0C;

  // status word fields (apb status word; the fields below bit 8 also in the link data byte)
  localparam int unsigned POS_CODE  = 0;
  localparam int unsigned POS_TB    = 5;
  localparam int unsigned POS_STATUS_WRITE_DISABLE  = 7;
  localparam int unsigned POS_WP    = 8;
  localparam int unsigned POS_PFLAG = 9;
  // lock data fields
  localparam int unsigned POS_WLOCK = 0;
  localparam int unsigned POS_LDOWN = 1;
  // interrupt bits
  localparam int unsigned IRQ_PROT   = 0;
  localparam int unsigned IRQ_LOCKIG = 1;
  localparam int unsigned IRQ_SRREJ  = 2;
  localparam int unsigned IRQ_DONE   = 3;
  localparam int unsigned IRQ_BITS   = 4;
  // last-request word fields
  localparam int unsigned POS_LSECT = 0;
  localparam int unsigned POS_LREJ  = 8;
  localparam int unsigned POS_LBOOT = 9;

  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic       RST_TB   = 1'b0;
  localparam logic       RST_STATUS_WRITE_DISABLE = 1'b0;
  localparam logic [IRQ_BITS-1:0] RST_MASK = 4'h0;

  typedef enum logic [1:0] {
    fsp_uniform,
    fsp_bottom_boot,
    fsp_top_boot
  } fsp_arch_type;

  typedef enum logic [2:0] {
    fsp_op_none,
    fsp_op_lock_read,
    fsp_op_lock_write,
    fsp_op_program,
    fsp_op_erase,
    fsp_op_subsector_erase,
    fsp_op_status_write,
    fsp_op_clear_flags
  } fsp_op_type;

  typedef enum {
    fsp_st_idle,
    fsp_st_exec
  } fsp_state_type;
endpackage
`default_nettype wire

/* File: verilog/fsp_range.sv */
`default_nettype none
module fsp_range #(
  parameter fsp_pkg::fsp_arch_type ARCH = fsp_pkg::fsp_uniform
) (
  fsp_range_if.decoder rif
);
  import fsp_pkg::*;

  logic [SECTOR_BITS:0] count;
  logic [SECTOR_BITS:0] sect9;

  always_comb begin
    sect9 = {1'b0, rif.sector};
    if (rif.code == 4'h0) begin
      count = '0;
    end else if (rif.code >= 4'(CODE_ALL_MIN)) begin
      count = (SECTOR_BITS+1)'(NUM_SECTORS);
    end else begin
      count = (SECTOR_BITS+1)'(1) << (rif.code - 4'h1);
    end
    // top/bottom picks the end of the array the range grows from
    if (rif.tb) begin
      rif.hit = sect9 < count;
    end else begin
      rif.hit = sect9 >= ((SECTOR_BITS+1)'(NUM_SECTORS) - count);
    end
    case (ARCH)
      fsp_bottom_boot: rif.boot = sect9 < (SECTOR_BITS+1)'(BOOT_SECTORS);
      fsp_top_boot:    rif.boot = sect9 >= (SECTOR_BITS+1)'(NUM_SECTORS
                                  - BOOT_SECTORS);
      default:         rif.boot = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/fsp_range_if.sv */
`default_nettype none
interface fsp_range_if;
  import fsp_pkg::*;
  logic [SECTOR_BITS-1:0] sector;
  logic [3:0]             code;
  logic                   tb;
  logic                   hit;
  logic                   boot;
  modport requester (output sector, output code, output tb,
                     input hit, input boot);
  modport decoder   (input sector, input code, input tb,
                     output hit, output boot);
endinterface
`default_nettype wire

/* File: verilog/fsp_top.sv */
`default_nettype none
module fsp_top #(
  parameter fsp_pkg::fsp_arch_type ARCH = fsp_pkg::fsp_uniform
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               irq,
  input  wire logic                          link_sclk,
  input  wire logic                          link_req,
  input  wire logic [2:0]                    link_op,
  input  wire logic [fsp_pkg::SECTOR_BITS-1:0] link_sector,
  input  wire logic [7:0]                    link_data,
  input  wire logic                          write_protect_n,
  output logic      [7:0]                    link_rdata,
  output logic                               link_reject,
  output logic                               link_ack
);
  import fsp_pkg::*;

  localparam int unsigned SYNC_W = 1 + 1 + 3 + SECTOR_BITS + 8 + 1;
  // protect pin idles high; a zero here would fake a protect state
  localparam logic [SYNC_W-1:0] SYNC_RST = SYNC_W'(1);

  // refuse shapes the decoders cannot serve
  if (ARCH != fsp_uniform && ARCH != fsp_bottom_boot
      && ARCH != fsp_top_boot) begin : g_bad_arch
    $error("unsupported array architecture");
  end
  if (NUM_SECTORS != (1 << SECTOR_BITS)) begin : g_bad_count
    $error("sector count must fill the sector index");
  end
  if (BOOT_SECTORS > NUM_SECTORS) begin : g_bad_boot
    $error("more boot sectors than sectors");
  end
  if (CODE_ALL_MIN > SECTOR_BITS + 2) begin : g_bad_code
    $error("range code threshold out of reach");
  end

  typedef struct packed {
    logic [SYNC_W-1:0]      sync1;
    logic [SYNC_W-1:0]      sync2;
    logic                   sclk_prev;
    fsp_state_type          state;
    fsp_op_type             op;
    logic [SECTOR_BITS-1:0] sector;
    logic [7:0]             data;
    logic [NUM_SECTORS-1:0] wlock;
    logic [NUM_SECTORS-1:0] ldown;
    logic [3:0]             code;
    logic                   tb;
    logic                   status_write_disable;
    logic                   prot_flag;
    logic [IRQ_BITS-1:0]    int_stat;
    logic [IRQ_BITS-1:0]    int_mask;
    logic [SECTOR_BITS-1:0] last_sector;
    logic                   last_rej;
    logic                   last_boot;
    logic [7:0]             rdata;
    logic                   reject;
    logic                   ack;
    logic [31:0]            prdata;
    logic                   pslverr;
  } fsp_regs_type;

  fsp_regs_type s_r;
  fsp_regs_type s_nxt;

  fsp_range_if rif ();
  fsp_range #(.ARCH(ARCH)) u_range (.rif(rif));

  logic                   sclk_s;
  logic                   req_s;
  logic [2:0]             op_s;
  logic [SECTOR_BITS-1:0] sect_s;
  logic [7:0]             data_s;
  logic                   wp_active;
  logic                   sclk_rise;
  logic                   sect_locked;
  logic                   sect_prot;
  logic                   sr_frozen;
  logic                   apb_setup;
  logic                   apb_wr;
  logic                   mapped;
  logic [IRQ_BITS-1:0]    ev;
  logic [IRQ_BITS-1:0]    w1c;
  logic [31:0]            status_word;
  logic [NUM_SECTORS-1:0] sect_sel;
  logic [NUM_SECTORS-1:0] wlock_upd;
  logic [NUM_SECTORS-1:0] ldown_upd;
  logic                   lock_wr_ok;

  assign {sclk_s, req_s, op_s, sect_s, data_s} = s_r.sync2[SYNC_W-1:1];
  assign wp_active = ~s_r.sync2[0];
  assign sclk_rise = sclk_s & ~s_r.sclk_prev;

  assign rif.sector = s_r.sector;
  assign rif.code   = s_r.code;
  assign rif.tb     = s_r.tb;

  assign sect_locked = s_r.wlock[s_r.sector];
  assign sect_prot   = sect_locked | rif.hit;
  // joint hardware lock of the status bits
  assign sr_frozen   = wp_active & s_r.status_write_disable;

  // lock write lands only while the addressed lock-down bit is clear
  assign lock_wr_ok = (s_r.state == fsp_st_exec)
                      && (s_r.op == fsp_op_lock_write)
                      && !s_r.ldown[s_r.sector];

  // one lock cell per sector; each keeps its bits unless addressed
  for (genvar i = 0; i < NUM_SECTORS; i++) begin : g_lock
    assign sect_sel[i]  = s_r.sector == SECTOR_BITS'(i);
    assign wlock_upd[i] = (lock_wr_ok && sect_sel[i])
                          ? s_r.data[POS_WLOCK] : s_r.wlock[i];
    assign ldown_upd[i] = (lock_wr_ok && sect_sel[i])
                          ? s_r.data[POS_LDOWN] : s_r.ldown[i];
  end

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;
  assign mapped    = (paddr == OFF_STATUS) || (paddr == OFF_INT_STAT)
                     || (paddr == OFF_INT_MASK) || (paddr == OFF_LAST);
  assign w1c = (apb_wr && paddr == OFF_INT_STAT)
               ? pwdata[IRQ_BITS-1:0] : '0;

  always_comb begin
    status_word = '0;
    status_word[POS_CODE +: 4] = s_r.code;
    status_word[POS_TB]        = s_r.tb;
    status_word[POS_STATUS_WRITE_DISABLE]      = s_r.status_write_disable;
    status_word[POS_WP]        = wp_active;
    status_word[POS_PFLAG]     = s_r.prot_flag;
  end

  always_comb begin
    s_nxt = s_r;
    ev    = '0;
    s_nxt.sync1     = {link_sclk, link_req, link_op, link_sector,
                       link_data, write_protect_n};
    s_nxt.sync2     = s_r.sync1;
    s_nxt.sclk_prev = sclk_s;

    case (s_r.state)
      fsp_st_idle: begin
        // request captured on a serial clock rising edge
        if (sclk_rise && req_s) begin
          s_nxt.op     = fsp_op_type'(op_s);
          s_nxt.sector = sect_s;
          s_nxt.data   = data_s;
          s_nxt.state  = fsp_st_exec;
        end
      end
      fsp_st_exec: begin
        // one cycle so the range decoder sees the captured sector
        s_nxt.state       = fsp_st_idle;
        s_nxt.reject      = 1'b0;
        s_nxt.last_sector = s_r.sector;
        s_nxt.last_boot   = rif.boot;
        case (s_r.op)
          fsp_op_lock_read: begin
            s_nxt.rdata = '0;
            s_nxt.rdata[POS_WLOCK] = s_r.wlock[s_r.sector];
            s_nxt.rdata[POS_LDOWN] = s_r.ldown[s_r.sector];
          end
          fsp_op_lock_write: begin
            if (s_r.ldown[s_r.sector]) begin
              s_nxt.reject = 1'b1;
              ev[IRQ_LOCKIG] = 1'b1;
            end else begin
              s_nxt.wlock = wlock_upd;
              s_nxt.ldown = ldown_upd;
            end
          end
          fsp_op_program,
          fsp_op_erase,
          fsp_op_subsector_erase: begin
            if (sect_prot) begin
              s_nxt.reject   = 1'b1;
              ev[IRQ_PROT]   = 1'b1;
            end else if (s_r.op == fsp_op_subsector_erase && !rif.boot) begin
              // subsectors exist only in boot sectors
              s_nxt.reject = 1'b1;
            end
          end
          fsp_op_status_write: begin
            if (sr_frozen) begin
              s_nxt.reject  = 1'b1;
              ev[IRQ_SRREJ] = 1'b1;
              ev[IRQ_PROT]  = 1'b1;
            end else if (wp_active) begin
              // pin alone: protected bits hold, write is rejected and raises only the done interrupt, no flag
              s_nxt.reject = 1'b1;
            end else begin
              s_nxt.code = s_r.data[POS_CODE +: 4];
              s_nxt.tb   = s_r.data[POS_TB];
              s_nxt.status_write_disable = s_r.data[POS_STATUS_WRITE_DISABLE];
            end
          end
          fsp_op_clear_flags: begin
            s_nxt.prot_flag = 1'b0;
          end
          default: begin
            s_nxt.rdata = status_word[7:0];
          end
        endcase
        s_nxt.last_rej = s_nxt.reject;
        ev[IRQ_DONE]   = 1'b1;
        s_nxt.ack      = ~s_r.ack;
      end
      default: begin
        s_nxt.state = fsp_st_idle;
      end
    endcase

    // set wins over clear
    if (ev[IRQ_PROT]) begin
      s_nxt.prot_flag = 1'b1;
    end
    s_nxt.int_stat = (s_r.int_stat & ~w1c) | ev;

    if (apb_wr && paddr == OFF_INT_MASK) begin
      s_nxt.int_mask = pwdata[IRQ_BITS-1:0];
    end
    // read data taken in setup, held through the access phase
    if (apb_setup) begin
      s_nxt.pslverr = ~mapped;
      case (paddr)
        OFF_STATUS:   s_nxt.prdata = status_word;
        OFF_INT_STAT: s_nxt.prdata = 32'(s_r.int_stat);
        OFF_INT_MASK: s_nxt.prdata = 32'(s_r.int_mask);
        OFF_LAST: begin
          s_nxt.prdata = '0;
          s_nxt.prdata[POS_LSECT +: SECTOR_BITS] = s_r.last_sector;
          s_nxt.prdata[POS_LREJ]  = s_r.last_rej;
          s_nxt.prdata[POS_LBOOT] = s_r.last_boot;
        end
        default:      s_nxt.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.sync1       <= SYNC_RST;
      s_r.sync2       <= SYNC_RST;
      s_r.sclk_prev   <= 1'b0;
      s_r.state       <= fsp_st_idle;
      s_r.op          <= fsp_op_none;
      s_r.sector      <= '0;
      s_r.data        <= '0;
      s_r.wlock       <= '0;
      s_r.ldown       <= '0;
      s_r.code        <= RST_CODE;
      s_r.tb          <= RST_TB;
      s_r.status_write_disable        <= RST_STATUS_WRITE_DISABLE;
      s_r.prot_flag   <= 1'b0;
      s_r.int_stat    <= '0;
      s_r.int_mask    <= RST_MASK;
      s_r.last_sector <= '0;
      s_r.last_rej    <= 1'b0;
      s_r.last_boot   <= 1'b0;
      s_r.rdata       <= '0;
      s_r.reject      <= 1'b0;
      s_r.ack         <= 1'b0;
      s_r.prdata      <= '0;
      s_r.pslverr     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata      = s_r.prdata;
  assign pready      = psel & penable;
  assign pslverr     = psel & penable & s_r.pslverr;
  assign irq         = |(s_r.int_stat & s_r.int_mask);
  assign link_rdata  = s_r.rdata;
  assign link_reject = s_r.reject;
  assign link_ack    = s_r.ack;
endmodule
`default_nettype wire
